//--- inc/bcd_cfg.svh
// Constants for the branch and compare decoder
// Assumes a 32-bit address space and 16-bit instruction words
`ifndef BCD_CFG_SVH
`define BCD_CFG_SVH
`define BCD_PC_STEP 32'h0000_0002
`define BCD_SP_STEP 32'h0000_0004
`define BCD_DISP_WORD 8'h00
`define BCD_DISP_LONG 8'hFF
`define BCD_OP_BRANCH 4'h6
`define BCD_OP_CMP 4'hB
`define BCD_COND_BRA 4'h0
`define BCD_COND_BSR 4'h1
`define BCD_CCR_RESET 5'h00
`define BCD_PC_RESET 32'h0000_0000
`define BCD_SP_RESET 32'h0000_0000
`endif

//--- inc/bcd_pkg.sv
// Types for the branch and compare decoder
// Assumes bcd_cfg.svh supplies the constants
package bcd_pkg;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } bcd_ccr_t;
  typedef struct packed {
    logic valid;
    logic [15:0] op;
    logic [31:0] ext;
    logic [31:0] op_addr;
    logic [31:0] src;
    logic [31:0] dst;
  } bcd_instr_t;
  typedef enum logic [2:0] {
    BCD_IDLE = 3'b001,
    BCD_EXEC = 3'b010,
    BCD_PUSH = 3'b100
  } bcd_state_t;
endpackage : bcd_pkg

//--- hw/bcd_decode.sv
// Branch and data-register compare decode and execute stage
// Assumes fetch supplies the opcode, up to 32 bits of extension and operands
//
// Overview of operation
// [RULE_01] Taken conditional branch loads PC plus sign-extended displacement
// [RULE_02] Branch base PC is the opcode address plus two
// [RULE_03] Byte displacement zero selects the following 16-bit word
// [RULE_04] Byte displacement all ones selects the following 32-bit longword
// [RULE_05] Displacements are signed byte distances, sign-extended to 32 bits
// [RULE_06] Software uses word form to branch to the next instruction
// [RULE_07] Subroutine call: SP minus 4, push return address, then jump
// [RULE_08] All three branches leave condition flags unchanged
// [RULE_09] Conditional branch supports fourteen named tests
// [RULE_10] Byte, word and long displacements accepted for every branch
// [RULE_11] Branch always redirects with the same displacement selection
// [RULE_12] Compare subtracts source from destination, flags only, no write
// [RULE_13] Compare works at byte, word or long size on low bits
// [RULE_14] Address and immediate compares are not this compare form
// [RULE_15] Compare sets N Z, V on overflow, C on borrow, keeps X
// [RULE_16] Conditions use the customary N Z V C combinations
// [RULE_17] Length decode reports one, two or three words per branch
`timescale 1ns/1ps
`include "bcd_cfg.svh"
module bcd_decode
  import bcd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire bcd_instr_t instr_i,
  output logic [31:0] pc_o,
  output logic pc_load_o,
  output logic [31:0] sp_o,
  output logic [31:0] push_addr_o,
  output logic [31:0] push_data_o,
  output logic push_valid_o,
  output bcd_ccr_t ccr_o,
  output logic [1:0] len_o,
  output logic illegal_o
);
  logic [31:0] pc_reg, pc_next, sp_reg, sp_next;
  logic [31:0] paddr_reg, paddr_next, pdata_reg, pdata_next;
  logic pc_load_reg, pc_load_next, push_reg, push_next;
  logic [1:0] len_reg, len_next;
  logic illegal_reg, illegal_next;
  bcd_ccr_t ccr_reg, ccr_next;
  logic [31:0] base, disp, target, ret;
  logic [3:0] cond;
  logic [7:0] d8;
  logic is_br, is_cmp, taken;
  logic [31:0] res;
  logic rn, sn, dn;
  logic [1:0] sz;

  always_comb
  begin
    cond = instr_i.op[11:8];
    d8 = instr_i.op[7:0];
    is_br = instr_i.op[15:12] == `BCD_OP_BRANCH;
    base = instr_i.op_addr + `BCD_PC_STEP; // [RULE_02]
    // Displacement form select [RULE_10]
    if (d8 == `BCD_DISP_WORD)
      disp = {{16{instr_i.ext[31]}}, instr_i.ext[31:16]}; // [RULE_03]
    else if (d8 == `BCD_DISP_LONG)
      disp = instr_i.ext; // [RULE_04]
    else
      disp = {{24{d8[7]}}, d8}; // [RULE_05]
    target = base + disp; // [RULE_01] [RULE_11]
    // Return address follows any extension words
    if (d8 == `BCD_DISP_WORD)
      ret = base + 32'h0000_0002;
    else if (d8 == `BCD_DISP_LONG)
      ret = base + 32'h0000_0004;
    else
      ret = base;
    // Condition tests [RULE_09] [RULE_16]
    unique case (cond)
      4'h0: taken = 1'b1;
      4'h1: taken = 1'b1;
      4'h2: taken = !ccr_reg.c && !ccr_reg.z;
      4'h3: taken = ccr_reg.c || ccr_reg.z;
      4'h4: taken = !ccr_reg.c;
      4'h5: taken = ccr_reg.c;
      4'h6: taken = !ccr_reg.z;
      4'h7: taken = ccr_reg.z;
      4'h8: taken = !ccr_reg.v;
      4'h9: taken = ccr_reg.v;
      4'hA: taken = !ccr_reg.n;
      4'hB: taken = ccr_reg.n;
      4'hC: taken = ccr_reg.n == ccr_reg.v;
      4'hD: taken = ccr_reg.n != ccr_reg.v;
      4'hE: taken = !ccr_reg.z && (ccr_reg.n == ccr_reg.v);
      4'hF: taken = ccr_reg.z || (ccr_reg.n != ccr_reg.v);
    endcase
    // Data-register compare only: opmode 000/001/010 [RULE_14]
    sz = instr_i.op[7:6];
    is_cmp = instr_i.op[15:12] == `BCD_OP_CMP && !instr_i.op[8]
      && sz != 2'b11;
    res = instr_i.dst - instr_i.src; // [RULE_12]
    // Size select of low-order bits [RULE_13]
    unique case (sz)
      2'b00:
      begin
        rn = res[7];
        sn = instr_i.src[7];
        dn = instr_i.dst[7];
      end
      2'b01:
      begin
        rn = res[15];
        sn = instr_i.src[15];
        dn = instr_i.dst[15];
      end
      default:
      begin
        rn = res[31];
        sn = instr_i.src[31];
        dn = instr_i.dst[31];
      end
    endcase
  end

  always_comb
  begin
    pc_next = pc_reg;
    sp_next = sp_reg;
    paddr_next = paddr_reg;
    pdata_next = pdata_reg;
    pc_load_next = 1'b0;
    push_next = 1'b0;
    len_next = len_reg;
    illegal_next = 1'b0;
    ccr_next = ccr_reg; // [RULE_08]
    if (instr_i.valid && is_br)
    begin
      // Length in words [RULE_17]
      if (d8 == `BCD_DISP_WORD)
        len_next = 2'd2;
      else if (d8 == `BCD_DISP_LONG)
        len_next = 2'd3;
      else
        len_next = 2'd1;
      if (taken)
      begin
        pc_next = target; // [RULE_01] [RULE_11]
        pc_load_next = 1'b1;
      end
      else
        pc_next = ret;
      if (cond == `BCD_COND_BSR)
      begin
        sp_next = sp_reg - `BCD_SP_STEP; // [RULE_07]
        paddr_next = sp_reg - `BCD_SP_STEP;
        pdata_next = ret;
        push_next = 1'b1;
      end
    end
    else if (instr_i.valid && is_cmp)
    begin
      len_next = 2'd1;
      unique case (sz)
        2'b00: ccr_next.z = res[7:0] == 8'h00;
        2'b01: ccr_next.z = res[15:0] == 16'h0000;
        default: ccr_next.z = res == 32'h0000_0000;
      endcase
      ccr_next.n = rn; // [RULE_15]
      ccr_next.v = (dn != sn) && (rn != dn);
      ccr_next.c = (sn & !dn) | (rn & !dn) | (sn & rn);
    end
    else if (instr_i.valid)
      illegal_next = 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pc_reg <= `BCD_PC_RESET;
      sp_reg <= `BCD_SP_RESET;
      paddr_reg <= 32'h0000_0000;
      pdata_reg <= 32'h0000_0000;
      pc_load_reg <= 1'b0;
      push_reg <= 1'b0;
      len_reg <= 2'd0;
      illegal_reg <= 1'b0;
      ccr_reg <= `BCD_CCR_RESET;
    end
    else
    begin
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      paddr_reg <= paddr_next;
      pdata_reg <= pdata_next;
      pc_load_reg <= pc_load_next;
      push_reg <= push_next;
      len_reg <= len_next;
      illegal_reg <= illegal_next;
      ccr_reg <= ccr_next;
    end
  end

  assign pc_o = pc_reg;
  assign pc_load_o = pc_load_reg;
  assign sp_o = sp_reg;
  assign push_addr_o = paddr_reg;
  assign push_data_o = pdata_reg;
  assign push_valid_o = push_reg;
  assign ccr_o = ccr_reg;
  assign len_o = len_reg;
  assign illegal_o = illegal_reg;

  // Checks
  default clocking chk_cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  chk_bra_always: assert property ( // [RULE_11]
    instr_i.valid && is_br && cond == `BCD_COND_BRA |=> pc_load_o)
    else $error("branch always not taken");
  chk_target_calc: assert property ( // [RULE_01]
    instr_i.valid && is_br && taken |=> pc_o == $past(target))
    else $error("wrong branch target");
  chk_base_pc: assert property ( // [RULE_02]
    instr_i.valid && is_br && d8 == 8'h02 && taken
    |=> pc_o == $past(instr_i.op_addr) + 32'h0000_0004)
    else $error("base pc not opcode plus two");
  chk_word_len: assert property ( // [RULE_03]
    instr_i.valid && is_br && d8 == 8'h00 |=> len_o == 2'd2)
    else $error("word form length wrong");
  chk_long_len: assert property ( // [RULE_04]
    instr_i.valid && is_br && d8 == 8'hFF |=> len_o == 2'd3)
    else $error("long form length wrong");
  chk_neg_disp: assert property ( // [RULE_05]
    instr_i.valid && is_br && taken && d8 == 8'hFE
    |=> pc_o == $past(instr_i.op_addr))
    else $error("negative displacement wrong");
  chk_bsr_push: assert property ( // [RULE_07]
    instr_i.valid && is_br && cond == `BCD_COND_BSR
    |=> push_valid_o && sp_o == $past(sp_o) - 32'h0000_0004
    && push_addr_o == sp_o)
    else $error("subroutine push wrong");
  chk_br_flags: assert property ( // [RULE_08]
    instr_i.valid && is_br |=> $stable(ccr_o))
    else $error("branch changed flags");
  chk_cmp_x: assert property ( // [RULE_15]
    instr_i.valid && is_cmp |=> ccr_o.x == $past(ccr_o.x))
    else $error("compare changed extend");
  chk_cmp_zero: assert property ( // [RULE_12]
    instr_i.valid && is_cmp && instr_i.src == instr_i.dst
    |=> ccr_o.z && !ccr_o.c && !ccr_o.n)
    else $error("equal compare flags wrong");
  chk_cmp_byte: assert property ( // [RULE_13]
    instr_i.valid && is_cmp && sz == 2'b00
    && instr_i.src[7:0] == instr_i.dst[7:0] |=> ccr_o.z)
    else $error("byte compare not low bits");
  chk_not_compare_address_reg: assert property ( // [RULE_14]
    instr_i.valid && instr_i.op[15:12] == `BCD_OP_CMP && instr_i.op[8]
    |=> illegal_o && $stable(ccr_o))
    else $error("address compare decoded as data compare");
  chk_cc_test: assert property ( // [RULE_09] [RULE_16]
    instr_i.valid && is_br && cond == 4'h7 && !ccr_reg.z
    |=> !pc_load_o)
    else $error("equal test taken with z clear");
  chk_len_byte: assert property ( // [RULE_17]
    instr_i.valid && is_br && d8 == 8'h10 |=> len_o == 2'd1)
    else $error("byte form length wrong");
  cov_bsr: cover property (@(posedge core_clk_i) push_valid_o);
  cov_long: cover property (@(posedge core_clk_i)
    instr_i.valid && is_br && d8 == 8'hFF && taken);
  cov_cmp_borrow: cover property (@(posedge core_clk_i) is_cmp ##1 ccr_o.c);
  cov_not_taken: cover property (@(posedge core_clk_i)
    instr_i.valid && is_br && !taken);
endmodule : bcd_decode

//--- dv/bcd_fetch_model.sv
// Fetch path model: presents queued instructions, one per cycle
// Assumes the bench queues entries only at rising clock edges
`timescale 1ns/1ps
module bcd_fetch_model
  import bcd_pkg::*;
(
  input wire logic core_clk_i,
  output bcd_instr_t instr_o
);
  bcd_instr_t q[$];
  bcd_instr_t last = '0;
  initial instr_o = '0;
  // Idle cycles show the inverse of the last entry, valid low
  always @(negedge core_clk_i)
  begin
    if (q.size() > 0)
    begin
      last = q.pop_front();
      instr_o <= last;
    end
    else
      instr_o <= {1'b0, ~last[$bits(bcd_instr_t)-2:0]};
  end
endmodule : bcd_fetch_model

//--- dv/test_branch_compare_decode.sv
// Self-checking bench for the branch and compare decoder
// Assumes the fetch model feeds instr_i one entry per cycle
`timescale 1ns/1ps
`include "bcd_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_branch_compare_decode
  import bcd_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  bcd_instr_t instr_i;
  logic [31:0] pc_o, sp_o, push_addr_o, push_data_o;
  logic pc_load_o, push_valid_o, illegal_o;
  bcd_ccr_t ccr_o;
  logic [1:0] len_o;
  int err_total = 0;
  int checks = 0;
  logic [31:0] exp_pc = `BCD_PC_RESET;
  logic [31:0] exp_sp = `BCD_SP_RESET;
  bcd_ccr_t exp_ccr = `BCD_CCR_RESET;
  logic [65:0] vec [7] = '{{2'd2, 32'h5, 32'h5}, {2'd2, 32'h1, 32'h2},
    {2'd2, 32'h8000_0000, 32'h1}, {2'd2, 32'h3, 32'h1},
    {2'd0, 32'h1234_5680, 32'hFFFF_FF01}, {2'd1, 32'h1, 32'h0001_0002},
    {2'd0, 32'h77, 32'hFFFF_FF77}};

  initial
  begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  bcd_fetch_model fm_u (.core_clk_i(core_clk_i), .instr_o(instr_i));
  bcd_decode dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .instr_i(instr_i), .pc_o(pc_o), .pc_load_o(pc_load_o), .sp_o(sp_o),
    .push_addr_o(push_addr_o), .push_data_o(push_data_o),
    .push_valid_o(push_valid_o), .ccr_o(ccr_o), .len_o(len_o),
    .illegal_o(illegal_o));

  function automatic bcd_ccr_t cmp_flags(input logic [1:0] sz,
    input logic [31:0] d, input logic [31:0] s);
    logic [31:0] m, r, hb;
    m = sz == 0 ? 32'h0000_00FF : sz == 1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    hb = (m >> 1) + 32'h1;
    r = (d - s) & m;
    cmp_flags.x = exp_ccr.x;
    cmp_flags.n = |(r & hb);
    cmp_flags.z = r == 0;
    cmp_flags.v = |((d ^ s) & (d ^ r) & hb);
    cmp_flags.c = (s & m) > (d & m);
  endfunction : cmp_flags

  function automatic logic cond_ok(input logic [3:0] cc, input bcd_ccr_t f);
    logic ge;
    logic [15:0] t;
    ge = f.n == f.v;
    t = {f.z | !ge, !f.z & ge, !ge, ge, f.n, !f.n, f.v, !f.v, f.z, !f.z,
      f.c, !f.c, f.c | f.z, !f.c & !f.z, 2'b11};
    cond_ok = t[cc];
  endfunction : cond_ok

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic do_br(input logic [3:0] cc, input int form,
    input logic [31:0] addr, input logic pre, input bcd_instr_t cmp,
    input logic [7:0] db);
    logic [31:0] disp, nxt;
    logic take;
    bcd_instr_t br;
    disp = form == 0 ? {{24{db[7]}}, db} : form == 1 ? 32'h0000_0002
      : 32'h8000_0000;
    // Word form with offset two reaches the next instruction
    br = '{1'b1, {4'h6, cc, form == 0 ? db : form == 1 ? `BCD_DISP_WORD
      : `BCD_DISP_LONG}, form == 1 ? 32'h0002_5A5A : disp, addr,
      32'h0, 32'h0};
    nxt = addr + `BCD_PC_STEP + 32'(2 * form);
    take = cc < 4'h2 || cond_ok(cc, exp_ccr);
    @(posedge core_clk_i);
    if (pre)
    begin
      fm_u.q.push_back(cmp);
      @(posedge core_clk_i);
    end
    fm_u.q.push_back(br);
    @(negedge core_clk_i);
    if (pre)
      `CHK(ccr_o, exp_ccr)
    @(negedge core_clk_i);
    exp_pc = take ? addr + `BCD_PC_STEP + disp : nxt;
    if (cc == `BCD_COND_BSR)
    begin
      exp_sp = exp_sp - `BCD_SP_STEP;
      `CHK(push_addr_o, exp_sp)
      `CHK(push_data_o, nxt)
    end
    `CHK(push_valid_o, cc == `BCD_COND_BSR)
    `CHK(sp_o, exp_sp)
    `CHK(pc_o, exp_pc)
    `CHK(pc_load_o, take)
    `CHK(len_o, 2'(form + 1))
    `CHK(ccr_o, exp_ccr)
    `CHK(illegal_o, 1'b0)
  endtask : do_br

  task automatic t_forms;
    for (int cc = 0; cc < 2; cc++)
      for (int f = 0; f < 3; f++)
        do_br(4'(cc), f, 32'h0000_4000 + 32'(f * 16), 1'b0, '0,
          cc == 0 ? 8'h02 : 8'hFE);
    $display("test forms done");
  endtask : t_forms

  task automatic t_cond;
    bcd_instr_t c;
    for (int i = 0; i < 7; i++)
      for (int cc = 2; cc < 16; cc++)
      begin
        c = '{1'b1, {4'hB, 4'h0, vec[i][65:64], 6'h0}, 32'h0, 32'h0,
          vec[i][31:0], vec[i][63:32]};
        exp_ccr = cmp_flags(vec[i][65:64], vec[i][63:32], vec[i][31:0]);
        do_br(4'(cc), cc % 3, 32'h0001_0000 + 32'(cc * 8), 1'b1, c,
          i % 2 == 1 ? 8'h10 : 8'h80);
      end
    $display("test conditions done");
  endtask : t_cond

  task automatic t_illegal;
    logic [15:0] ops [4] = '{16'hB1C0, 16'hB0C0, 16'h0C80, 16'h4E71};
    bcd_instr_t v;
    foreach (ops[i])
    begin
      v = '{1'b1, ops[i], 32'h0, 32'h0, 32'h1, 32'h2};
      @(posedge core_clk_i);
      fm_u.q.push_back(v);
      @(negedge core_clk_i);
      @(negedge core_clk_i);
      `CHK(illegal_o, 1'b1)
      `CHK(ccr_o, exp_ccr)
      `CHK(pc_load_o, 1'b0)
      `CHK(pc_o, exp_pc)
    end
    $display("test refused done");
  endtask : t_illegal

  initial
  begin
    repeat (6) @(negedge core_clk_i);
    reset_i = 1'b0;
    t_forms();
    t_cond();
    t_illegal();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    complete_run();
  end
endmodule : test_branch_compare_decode
